// ---- rtl/brg_pkg.sv ----
/*
 * Package for the bus-reset and gap-count control block: register indices,
 * field positions, reset values and encodings shared by both ends.
 * Assumes the PHY register port carries a 4-bit register index and 8-bit data.
 */
`default_nettype none
package brg_pkg;
   localparam logic [3:0] REG_RESET_GAP    = 4'h1;
   localparam logic [3:0] REG_FEATURE      = 4'h5;
   localparam int         GAP_LSB          = 0;
   localparam int         GAP_W            = 6;
   localparam int         HOLDOFF_BIT      = 7;
   localparam int         LONG_RESET_BIT   = 6;
   localparam int         SHORT_RESET_BIT  = 1;
   localparam int         ACCEL_BIT        = 6;
   localparam int         CONCAT_BIT       = 5;
   localparam logic [5:0] GAP_MAX          = 6'h3f;
   localparam logic [7:0] FEATURE_RST      = 8'h00;
   localparam logic [7:0] FEATURE_WMASK    = 8'h60;
   localparam logic       HOLDOFF_RST      = 1'b0;
   localparam logic [1:0] RESET_NONE       = 2'h0;
   localparam logic [1:0] RESET_SHORT      = 2'h1;
   localparam logic [1:0] RESET_LONG       = 2'h2;
   // Controller-side Avalon registers.
   localparam logic [3:0] CSR_CMD          = 4'h0;
   localparam logic [3:0] CSR_STATUS       = 4'h4;
   localparam logic [3:0] CSR_FEATURE      = 4'h8;
   localparam logic [3:0] CSR_SNAPSHOT     = 4'hc;
   localparam int         CMD_SHORT_BIT    = 0;
   localparam int         CMD_LONG_CFG_BIT = 1;
   localparam int         CMD_LONG_ANY_BIT = 2;
   localparam int         CMD_READ_BIT     = 3;
endpackage : brg_pkg
`default_nettype wire

// ---- rtl/brg_if.sv ----
/*
 * Interface joining the device's PHY register port and the controller.
 * Assumes one clock; a request is a one-cycle strobe, a read answers next cycle.
 */
`default_nettype none
interface brg_if (
   input wire logic sys_clk
);
   logic       wr_stb;
   logic       rd_stb;
   logic [3:0] reg_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   logic       rd_valid;
   logic       busy;

   modport device (
      input  wr_stb, rd_stb, reg_addr, wr_data,
      output rd_data, rd_valid, busy
   );
   modport ctrl (
      output wr_stb, rd_stb, reg_addr, wr_data,
      input  rd_data, rd_valid, busy
   );
endinterface : brg_if
`default_nettype wire

// ---- rtl/brg_device.sv ----
/*
 * Device end: PHY registers 1 and 5, bus-reset triggers and gap-count keeper.
 * Assumes bus resets and configuration packets are signalled as one-cycle
 * pulses by the surrounding PHY logic, synchronous to sys_clk.
 */
`default_nettype none
module brg_device (
   // Clock and reset.
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   // Link to the controller.
   brg_if.device           link,
   // Events from the PHY core.
   input  wire logic       bus_reset_done,
   input  wire logic       cfg_pkt_valid,
   input  wire logic       cfg_pkt_holdoff,
   input  wire logic [5:0] cfg_pkt_gap,
   // Controls to the PHY core.
   output logic            short_reset_req,
   output logic            long_reset_req,
   output logic            root_holdoff_flag,
   output logic [5:0]      gap_count,
   output logic            accel_arb_enable,
   output logic            multispeed_concat_enable
);
   logic       holdoff_q;
   logic       holdoff_d;
   logic [5:0] gap_q;
   logic [5:0] gap_d;
   logic [7:0] feat_q;
   logic [7:0] feat_d;
   logic       seen_q;
   logic       seen_d;
   logic       short_q;
   logic       long_q;
   logic [7:0] rdata_q;
   logic       rvalid_q;
   logic       own_long_q;
   logic       own_long_d;

   wire        wr_r1   = link.wr_stb && (link.reg_addr == brg_pkg::REG_RESET_GAP);
   wire        wr_r5   = link.wr_stb && (link.reg_addr == brg_pkg::REG_FEATURE);
   wire        set_lr  = wr_r1 && link.wr_data[brg_pkg::LONG_RESET_BIT];
   wire        set_sr  = wr_r5 && link.wr_data[brg_pkg::SHORT_RESET_BIT];
   wire        load    = wr_r1 || cfg_pkt_valid;
   wire [7:0]  r1_view = {holdoff_q, long_q, gap_q};
   wire [7:0]  rd_sel  = (link.reg_addr == brg_pkg::REG_RESET_GAP) ? r1_view :
                         (link.reg_addr == brg_pkg::REG_FEATURE)   ? feat_q  : 8'h00;

   always_comb begin
      holdoff_d  = holdoff_q;
      gap_d      = gap_q;
      seen_d     = seen_q;
      own_long_d = own_long_q;
      if (bus_reset_done) begin
         own_long_d = 1'b0;
         if (own_long_q) begin
            seen_d = 1'b0;
         end else if (seen_q) begin
            gap_d  = brg_pkg::GAP_MAX;
            seen_d = 1'b0;
         end else begin
            seen_d = 1'b1;
         end
      end
      // A long-reset write in the same cycle as a finished bus reset is the newer event.
      if (set_lr) begin
         own_long_d = 1'b1;
      end
      if (cfg_pkt_valid) begin
         holdoff_d = cfg_pkt_holdoff;
         gap_d     = cfg_pkt_gap;
      end
      if (wr_r1) begin
         holdoff_d = link.wr_data[brg_pkg::HOLDOFF_BIT];
         gap_d     = link.wr_data[brg_pkg::GAP_LSB +: brg_pkg::GAP_W];
      end
      if (load) begin
         seen_d = 1'b0;
      end
   end

   // Trigger bits are self-clearing; only the feature bits are stored.
   assign feat_d = wr_r5 ? (link.wr_data & brg_pkg::FEATURE_WMASK) : feat_q;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         holdoff_q  <= brg_pkg::HOLDOFF_RST;
         gap_q      <= brg_pkg::GAP_MAX;
         feat_q     <= brg_pkg::FEATURE_RST;
         seen_q     <= 1'b0;
         own_long_q <= 1'b0;
         short_q    <= 1'b0;
         long_q     <= 1'b0;
         rdata_q    <= 8'h00;
         rvalid_q   <= 1'b0;
      end else begin
         holdoff_q  <= holdoff_d;
         gap_q      <= gap_d;
         feat_q     <= feat_d;
         seen_q     <= seen_d;
         own_long_q <= own_long_d;
         short_q    <= set_sr;
         long_q     <= set_lr;
         rdata_q    <= link.rd_stb ? rd_sel : rdata_q;
         rvalid_q   <= link.rd_stb;
      end
   end

   assign short_reset_req          = short_q;
   assign long_reset_req           = long_q;
   assign root_holdoff_flag        = holdoff_q;
   assign gap_count                = gap_q;
   assign accel_arb_enable         = feat_q[brg_pkg::ACCEL_BIT];
   assign multispeed_concat_enable = feat_q[brg_pkg::CONCAT_BIT];
   assign link.rd_data             = rdata_q;
   assign link.rd_valid            = rvalid_q;
   assign link.busy                = 1'b0;
endmodule : brg_device
`default_nettype wire

// ---- rtl/brg_ctrl.sv ----
/*
 * Controller end: Avalon-MM slave for software, issues PHY register
 * sequences that keep the reset and gap-count discipline.
 * Assumes the device answers a read strobe with rd_valid one cycle later.
 */
`default_nettype none
module brg_ctrl (
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // Avalon-MM slave.
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Link to the device.
   brg_if.ctrl              link
);
   typedef enum logic [4:0] {
      S_IDLE  = 5'b00001,
      S_RD    = 5'b00010,
      S_WAIT  = 5'b00100,
      S_WR    = 5'b01000,
      S_DONE  = 5'b10000
   } brg_state_e;

   brg_state_e state_q;
   logic [1:0] kind_q;
   logic [3:0] addr_q;
   logic [7:0] wdata_q;
   logic [7:0] feat_q;
   logic [7:0] snap_q;
   logic       busy_q;
   logic       wr_q;
   logic       rd_q;
   logic [31:0] rdata_q;
   logic       wait_q;

   wire acc   = (avs_read || avs_write) && !wait_q;
   wire cmd_w = acc && avs_write && (avs_address == brg_pkg::CSR_CMD) && !busy_q;
   wire go_sr = cmd_w && avs_writedata[brg_pkg::CMD_SHORT_BIT];
   wire go_lc = cmd_w && avs_writedata[brg_pkg::CMD_LONG_CFG_BIT];
   wire go_la = cmd_w && avs_writedata[brg_pkg::CMD_LONG_ANY_BIT];
   wire go_rd = cmd_w && avs_writedata[brg_pkg::CMD_READ_BIT];
   wire feat_w = acc && avs_write && (avs_address == brg_pkg::CSR_FEATURE) && !busy_q;
   wire [7:0] feat_wr = avs_writedata[7:0] & brg_pkg::FEATURE_WMASK;
   wire [31:0] csr_rd =
      (avs_address == brg_pkg::CSR_STATUS)   ? {31'h0, busy_q} :
      (avs_address == brg_pkg::CSR_FEATURE)  ? {24'h0, feat_q} :
      (avs_address == brg_pkg::CSR_SNAPSHOT) ? {24'h0, snap_q} : 32'h0;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_q <= S_IDLE;
         kind_q  <= brg_pkg::RESET_NONE;
         addr_q  <= 4'h0;
         wdata_q <= 8'h00;
         feat_q  <= brg_pkg::FEATURE_RST;
         snap_q  <= 8'h00;
         busy_q  <= 1'b0;
         wr_q    <= 1'b0;
         rd_q    <= 1'b0;
         rdata_q <= 32'h0;
         wait_q  <= 1'b1;
      end else begin
         wr_q    <= 1'b0;
         rd_q    <= 1'b0;
         // Waitrequest drops for one cycle after a request is first seen; read data is
         // captured then so that it stands at the edge where the master takes it.
         wait_q  <= !((avs_read || avs_write) && wait_q);
         if (avs_read && wait_q) begin
            rdata_q <= csr_rd;
         end
         case (state_q)
            S_IDLE: begin
               if (go_sr) begin
                  // Other feature bits are written back unchanged.
                  wr_q    <= 1'b1;
                  addr_q  <= brg_pkg::REG_FEATURE;
                  wdata_q <= feat_q | 8'h02;
                  busy_q  <= 1'b1;
                  state_q <= S_DONE;
               end else if (go_lc || go_la || go_rd) begin
                  kind_q  <= go_rd ? brg_pkg::RESET_NONE :
                             (go_lc ? brg_pkg::RESET_LONG : brg_pkg::RESET_SHORT);
                  rd_q    <= 1'b1;
                  addr_q  <= brg_pkg::REG_RESET_GAP;
                  busy_q  <= 1'b1;
                  state_q <= S_WAIT;
               end else if (feat_w) begin
                  // The device bits follow the mirror, so a later short reset keeps them.
                  feat_q  <= feat_wr;
                  wr_q    <= 1'b1;
                  addr_q  <= brg_pkg::REG_FEATURE;
                  wdata_q <= feat_wr;
                  busy_q  <= 1'b1;
                  state_q <= S_DONE;
               end
            end
            S_WAIT: begin
               if (link.rd_valid) begin
                  snap_q  <= link.rd_data;
                  state_q <= (kind_q == brg_pkg::RESET_NONE) ? S_IDLE : S_WR;
                  busy_q  <= (kind_q != brg_pkg::RESET_NONE);
               end
            end
            S_WR: begin
               wr_q <= 1'b1;
               if (kind_q == brg_pkg::RESET_LONG) begin
                  wdata_q <= snap_q | 8'h40;
               end else begin
                  wdata_q <= {snap_q[brg_pkg::HOLDOFF_BIT], 1'b1, brg_pkg::GAP_MAX};
               end
               state_q <= S_DONE;
            end
            S_DONE: begin
               busy_q  <= 1'b0;
               state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // Gap count is never written without the long-reset bit set.
   assign link.wr_stb      = wr_q;
   assign link.rd_stb      = rd_q;
   assign link.reg_addr    = addr_q;
   assign link.wr_data     = wdata_q;
   assign avs_readdata     = rdata_q;
   assign avs_waitrequest  = wait_q;
endmodule : brg_ctrl
`default_nettype wire

// ---- sim/brg_props.sv ----
/*
 * Checker for the device register link and the gap-count keeper.
 * Assumes one clock and a synchronous active-low reset.
 */
`default_nettype none
module brg_props (
   // Clock and reset.
   input wire logic       sys_clk,
   input wire logic       reset_n,
   // Register link.
   input wire logic       wr_stb,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] wr_data,
   // Core events.
   input wire logic       bus_reset_done,
   input wire logic       cfg_pkt_valid,
   input wire logic       cfg_pkt_holdoff,
   input wire logic [5:0] cfg_pkt_gap,
   // Device controls.
   input wire logic       short_reset_req,
   input wire logic       long_reset_req,
   input wire logic       root_holdoff_flag,
   input wire logic [5:0] gap_count,
   input wire logic       accel_arb_enable,
   input wire logic       multispeed_concat_enable
);
   wire logic w1 = wr_stb && reg_addr == brg_pkg::REG_RESET_GAP;
   wire logic w5 = wr_stb && reg_addr == brg_pkg::REG_FEATURE;
   wire logic sh = w5 && wr_data[brg_pkg::SHORT_RESET_BIT];
   wire logic upd = w1 || cfg_pkt_valid;
   logic own_q;
   logic seen_q;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // A reset right after an own long write is not counted towards the forced maximum.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         own_q  <= 1'b0;
         seen_q <= 1'b0;
      end else if (upd) begin
         own_q  <= w1 ? wr_data[brg_pkg::LONG_RESET_BIT] : own_q;
         seen_q <= 1'b0;
      end else if (bus_reset_done) begin
         own_q  <= 1'b0;
         seen_q <= seen_q || !own_q;
      end
   end
   AST_SHORT_REQ: assert property (sh |=> short_reset_req ##1 !short_reset_req)
      else $error("short reset request missing");
   AST_SHORT_KEEP: assert property (sh |-> wr_data[6] == accel_arb_enable
      && wr_data[5] == multispeed_concat_enable) else $error("feature bits changed");
   AST_LONG_REQ: assert property (w1 && wr_data[6] |=> long_reset_req ##1 !long_reset_req)
      else $error("long reset request missing");
   AST_REG1_LOAD: assert property (w1 |=> gap_count == $past(wr_data[5:0])
      && root_holdoff_flag == $past(wr_data[7])) else $error("register write not loaded");
   AST_PKT_LOAD: assert property (cfg_pkt_valid && !w1 |=> gap_count == $past(cfg_pkt_gap)
      && root_holdoff_flag == $past(cfg_pkt_holdoff)) else $error("packet not loaded");
   AST_TWO_RESET: assert property (bus_reset_done && !upd && seen_q && !own_q
      |=> gap_count == brg_pkg::GAP_MAX) else $error("gap not forced to maximum");
   AST_OWN_KEEP: assert property (bus_reset_done && !upd && own_q |=> $stable(gap_count))
      else $error("own long reset changed gap");
   AST_REG1_LONG: assert property (w1 |-> wr_data[brg_pkg::LONG_RESET_BIT])
      else $error("register 1 written without long reset");
endmodule : brg_props
`default_nettype wire

// ---- sim/tb_bus_reset_gap_count_control.sv ----
/*
 * Testbench: controller and device joined by the link interface.
 * Assumes software reaches the controller over Avalon-MM.
 */
`default_nettype none
module tb_bus_reset_gap_count_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd;
   logic        avs_waitrequest, short_reset_req, long_reset_req, root_holdoff_flag;
   logic        accel_arb_enable, multispeed_concat_enable;
   logic        bus_reset_done = 1'b0;
   logic        cfg_pkt_valid = 1'b0;
   logic        cfg_pkt_holdoff = 1'b0;
   logic [5:0]  cfg_pkt_gap = 6'h00;
   logic [5:0]  gap_count;
   int          n_mismatch = 0, cmp_count = 0, n_short = 0, n_long = 0, cyc = 0;
   brg_if i_brg_if (.sys_clk(sys_clk));
   brg_device i_brg_device (.sys_clk, .reset_n, .link(i_brg_if.device), .bus_reset_done,
      .cfg_pkt_valid, .cfg_pkt_holdoff, .cfg_pkt_gap, .short_reset_req, .long_reset_req,
      .root_holdoff_flag, .gap_count, .accel_arb_enable, .multispeed_concat_enable);
   brg_ctrl i_brg_ctrl (.sys_clk, .reset_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .link(i_brg_if.ctrl));
   brg_props i_brg_props (.sys_clk, .reset_n, .wr_stb(i_brg_if.wr_stb),
      .reg_addr(i_brg_if.reg_addr), .wr_data(i_brg_if.wr_data), .bus_reset_done,
      .cfg_pkt_valid, .cfg_pkt_holdoff, .cfg_pkt_gap, .short_reset_req, .long_reset_req,
      .root_holdoff_flag, .gap_count, .accel_arb_enable, .multispeed_concat_enable);
   initial forever #5 sys_clk = ~sys_clk;
   task close_out;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   always @(posedge sys_clk) begin
      cyc++;
      n_short += (short_reset_req === 1'b1);
      n_long += (long_reset_req === 1'b1);
      if (cyc == 20000) begin
         n_mismatch++;
         close_out();
      end
   end
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : av
   task cmd(input logic [3:0] bits);
      int k;
      k = 0;
      av(1'b1, brg_pkg::CSR_CMD, {28'h0, bits});
      do begin
         av(1'b0, brg_pkg::CSR_STATUS, 32'h0);
         k++;
      end while (rd[0] !== 1'b0 && k < 30);
      chk("idle", rd[0], 32'h0);
      repeat (3) @(posedge sys_clk);
   endtask : cmd
   task pkt(input logic h, input logic [5:0] g);
      @(posedge sys_clk);
      cfg_pkt_valid <= 1'b1;
      cfg_pkt_holdoff <= h;
      cfg_pkt_gap <= g;
      @(posedge sys_clk) cfg_pkt_valid <= 1'b0;
      @(posedge sys_clk);
   endtask : pkt
   task brst;
      @(posedge sys_clk) bus_reset_done <= 1'b1;
      @(posedge sys_clk) bus_reset_done <= 1'b0;
      @(posedge sys_clk);
   endtask : brst
   task t_reset_vals;
      chk("gap", gap_count, 32'h3f);
      chk("holdoff", root_holdoff_flag, 32'h0);
      av(1'b0, 4'h2, 32'h0);
      chk("unmapped", rd, 32'h0);
   endtask : t_reset_vals
   task t_short;
      int ns;
      for (int i = 0; i < 2; i++) begin
         av(1'b1, brg_pkg::CSR_FEATURE, i ? 32'h9f : 32'h60);
         repeat (2) @(posedge sys_clk);
         chk("feature", {accel_arb_enable, multispeed_concat_enable}, i ? 0 : 3);
         ns = n_short;
         cmd(4'h1);
         chk("short", n_short, ns + 1);
         chk("kept", {accel_arb_enable, multispeed_concat_enable}, i ? 0 : 3);
      end
   endtask : t_short
   task t_cfg_long;
      int nl;
      nl = n_long;
      pkt(1'b1, 6'h15);
      chk("pkt", {root_holdoff_flag, gap_count}, 32'h55);
      cmd(4'h2);
      chk("long", n_long, nl + 1);
      chk("rewrite", {root_holdoff_flag, gap_count}, 32'h55);
      cmd(4'h8);
      av(1'b0, brg_pkg::CSR_SNAPSHOT, 32'h0);
      chk("reg1", rd[7:0], 32'h95);
      brst();
      chk("own", gap_count, 32'h15);
      brst();
      chk("first", gap_count, 32'h15);
      brst();
      chk("second", gap_count, 32'h3f);
      pkt(1'b0, 6'h05);
      brst();
      pkt(1'b0, 6'h07);
      brst();
      chk("cleared", gap_count, 32'h07);
   endtask : t_cfg_long
   task t_long_any;
      int nl;
      pkt(1'b1, 6'h0a);
      nl = n_long;
      cmd(4'h4);
      chk("long", n_long, nl + 1);
      chk("other", {root_holdoff_flag, gap_count}, 32'h7f);
   endtask : t_long_any
   initial begin
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_reset_vals();
      t_short();
      t_cfg_long();
      t_long_any();
      close_out();
   end
endmodule : tb_bus_reset_gap_count_control
`default_nettype wire
